// file: design/spi_pkg.sv
// Package for the serial interrupt logic: register map, fields, resets,
// timing counts and shared enumerations.
// Assumes a 100 MHz system clock and a 32-bit classic Wishbone slave.
package spi_pkg;
  // Register byte offsets (word aligned, so index * 4)
  localparam logic [15:0] SPI_IDX_ENABLE = 16'hFF23;
  localparam logic [15:0] SPI_IDX_FLAGS = 16'hFF25;
  localparam logic [15:0] SPI_IDX_PRIO = 16'hFF20;
  localparam logic [15:0] SPI_IDX_CTRL = 16'hFF49;
  localparam logic [15:0] SPI_IDX_MODE = 16'hFF48;
  localparam logic [17:0] SPI_ADR_ENABLE = {SPI_IDX_ENABLE, 2'b00};
  localparam logic [17:0] SPI_ADR_FLAGS = {SPI_IDX_FLAGS, 2'b00};
  localparam logic [17:0] SPI_ADR_PRIO = {SPI_IDX_PRIO, 2'b00};
  localparam logic [17:0] SPI_ADR_CTRL = {SPI_IDX_CTRL, 2'b00};
  localparam logic [17:0] SPI_ADR_MODE = {SPI_IDX_MODE, 2'b00};
  // Field positions in the enable and flag registers
  localparam int SPI_BIT_TX = 0;
  localparam int SPI_BIT_RX = 1;
  localparam int SPI_BIT_ERR = 2;
  // Priority field position in the priority register
  localparam int SPI_PRIO_LSB = 4;
  // Control register fields
  localparam int SPI_CTL_TX_ON = 0;
  localparam int SPI_CTL_TX_GO = 1;
  localparam int SPI_CTL_RX_ON = 2;
  localparam int SPI_CTL_RX_GO = 3;
  localparam int SPI_CTL_OVR = 4;
  localparam int SPI_CTL_PAR = 5;
  localparam int SPI_CTL_FRM = 6;
  // Mode register fields
  localparam int SPI_MD_ASYNC = 0;
  localparam int SPI_MD_CLK_LSB = 3;
  localparam int SPI_MD_PODD = 5;
  localparam int SPI_MD_PEN = 6;
  // Reset values
  localparam logic [2:0] SPI_RST_ENABLE = 3'h0;
  localparam logic [2:0] SPI_RST_FLAGS = 3'h0;
  localparam logic [1:0] SPI_RST_PRIO = 2'h0;
  localparam logic [7:0] SPI_RST_MODE = 8'h00;
  // Clock source codes 0 to 3: /16, /8, /4 of the fast oscillator, timer
  localparam logic [1:0] SPI_SRC_TIMER = 2'h3;
  // Fast oscillator base division from system clock
  localparam int SPI_OSC_DIV = 2;
  // Half cycle of a divided source, in oscillator ticks, per code
  function automatic logic [4:0] spi_half_ticks(input logic [1:0] src);
    case (src)
      2'h2: spi_half_ticks = 5'h02;
      2'h1: spi_half_ticks = 5'h04;
      // Timer source: one whole underflow period
      2'h3: spi_half_ticks = 5'h01;
      default: spi_half_ticks = 5'h08;
    endcase
  endfunction : spi_half_ticks
  // Error-to-done gap sequencer states
  typedef enum logic [1:0] {
    SPI_GAP_IDLE = 2'b00,
    SPI_GAP_WAIT = 2'b01,
    SPI_GAP_DONE = 2'b10
  } spi_gap_t;
endpackage : spi_pkg

// file: design/spi_tick_div.sv
// Tick divider: one-cycle enable pulses of the fast oscillator rate.
// Assumes a single system clock; no second domain.
`timescale 1ns/10ps
module spi_tick_div
  import spi_pkg::*;
#(
  parameter int DIV = SPI_OSC_DIV
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Tick out
  output logic tick_o
);
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } spi_div_st_t;
  spi_div_st_t st_ff, nxt_st;

  ////////////////////////////////////////////////////////////////////////
  // Next state: count down, pulse at wrap
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.cnt == 8'h00) begin
      nxt_st.cnt = 8'(DIV - 1);
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt - 8'h01;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick_o = st_ff.tick;
endmodule : spi_tick_div

// file: design/spi_gap_seq.sv
// Gap sequencer: delays the receive-done event behind the fault event.
// Assumes start is a single pulse and ticks are one-cycle pulses.
`timescale 1ns/10ps
module spi_gap_seq
  import spi_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Delay control
  input wire logic start_i,
  input wire logic [4:0] ticks_i,
  input wire logic tick_i,
  // Delayed event
  output logic done_o
);
  typedef struct packed {
    spi_gap_t state;
    logic [4:0] cnt;
    logic done;
  } spi_gseq_st_t;
  spi_gseq_st_t st_ff, nxt_st;

  ////////////////////////////////////////////////////////////////////////
  // Next state: wait the given number of ticks, then pulse done
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    case (st_ff.state)
      SPI_GAP_IDLE: begin
        if (start_i) begin
          nxt_st.state = SPI_GAP_WAIT;
          nxt_st.cnt = ticks_i;
        end
      end
      SPI_GAP_WAIT: begin
        if (tick_i) begin
          nxt_st.cnt = st_ff.cnt - 5'h01;
          if (st_ff.cnt <= 5'h01) begin
            nxt_st.state = SPI_GAP_DONE;
          end
        end
      end
      SPI_GAP_DONE: begin
        nxt_st.done = 1'b1;
        nxt_st.state = SPI_GAP_IDLE;
      end
      default: begin
        nxt_st.state = SPI_GAP_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '{state: SPI_GAP_IDLE, cnt: 5'h00, done: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign done_o = st_ff.done;
endmodule : spi_gap_seq

// file: design/spi_irq.sv
// Serial port interrupt logic: enables, sticky flags, priority, fault
// ordering and the error status flags, behind a classic Wishbone slave.
// Assumes the shift engines give one-cycle event pulses and a timer
// underflow pulse; the CPU supplies its current two-bit mask level.
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/10ps
module spi_irq
  import spi_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [17:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Shift engine events
  input wire logic tx_shift_done_i,
  input wire logic rx_buf_load_i,
  input wire logic [7:0] rx_char_i,
  input wire logic rx_stop_bit_i,
  input wire logic tx_busy_i,
  input wire logic rx_busy_i,
  input wire logic timer_uflow_i,
  // CPU interrupt side
  input wire logic [1:0] cpu_mask_i,
  output logic irq_o,
  output logic [1:0] irq_level_o,
  // Control to shift engines
  output logic transmit_enable_o,
  output logic receive_enable_o,
  output logic transmit_trigger_o,
  output logic receive_trigger_o,
  output logic async_mode_o
);
  // Whole block state
  typedef struct packed {
    logic [2:0] en;       // Interrupt enables
    logic [2:0] flg;      // Sticky interrupt flags
    logic [1:0] prio;     // Priority level field
    logic [7:0] mode;     // Mode and clock source
    logic tx_on;          // Transmit enable
    logic rx_on;          // Receive enable
    logic tx_go_p;        // Transmit trigger pulse
    logic rx_go_p;        // Receive trigger pulse
    logic buf_full;       // Buffer not yet released
    logic ovr;            // Overrun status
    logic par;            // Parity status
    logic frm;            // Framing status
    logic ack;            // Bus acknowledge
    logic [31:0] rdat;    // Read data
    logic irq;            // Interrupt request
    logic [1:0] lvl;      // Presented level
  } spi_irq_st_t;
  spi_irq_st_t st_ff, nxt_st;

  // Divider tick and delayed receive-done pulse
  logic osc_tick;
  logic gap_done;
  logic gap_start;
  logic gap_tick;
  logic [4:0] gap_ticks;

  // Decode of a register byte address
  function automatic logic hit(input logic [17:0] a, input logic [17:0] r);
    hit = (a == r);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////
  // Receive fault detection
  logic is_async;
  logic par_bad;
  logic frm_bad;
  logic ovr_bad;
  logic any_pf;
  logic rx_ev;
  logic [1:0] clk_src;
  always_comb begin
    is_async = st_ff.mode[SPI_MD_ASYNC];
    clk_src = st_ff.mode[SPI_MD_CLK_LSB +: 2];
    rx_ev = rx_buf_load_i & st_ff.rx_on;
    par_bad = is_async & st_ff.mode[SPI_MD_PEN] &
      ((^rx_char_i) != st_ff.mode[SPI_MD_PODD]);
    frm_bad = is_async & ~rx_stop_bit_i;
    ovr_bad = is_async & st_ff.buf_full;
    any_pf = par_bad | frm_bad;
    // start gap on parity or framing
    gap_start = rx_ev & any_pf & ~ovr_bad;
    gap_ticks = spi_half_ticks(clk_src);
    gap_tick = (clk_src == SPI_SRC_TIMER) ? timer_uflow_i : osc_tick;
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  logic wr;
  logic rd;
  logic [2:0] set_ev;
  logic [7:0] wb;
  always_comb begin
    nxt_st = st_ff;
    wr = cyc_i & stb_i & we_i & ~st_ff.ack & sel_i[0];
    rd = cyc_i & stb_i & ~we_i & ~st_ff.ack;
    wb = dat_i[7:0];
    nxt_st.ack = cyc_i & stb_i & ~st_ff.ack;
    nxt_st.tx_go_p = 1'b0;
    nxt_st.rx_go_p = 1'b0;
    // Register writes
    if (wr && hit(adr_i, SPI_ADR_ENABLE)) begin
      nxt_st.en = wb[2:0];
    end
    if (wr && hit(adr_i, SPI_ADR_PRIO)) begin
      nxt_st.prio = wb[SPI_PRIO_LSB +: 2];
    end
    if (wr && hit(adr_i, SPI_ADR_MODE)) begin
      nxt_st.mode = wb;
    end
    if (wr && hit(adr_i, SPI_ADR_CTRL)) begin
      nxt_st.tx_on = wb[SPI_CTL_TX_ON];
      nxt_st.rx_on = wb[SPI_CTL_RX_ON];
      nxt_st.tx_go_p = wb[SPI_CTL_TX_GO];
      nxt_st.rx_go_p = wb[SPI_CTL_RX_GO];
      // shared bit clock: refuse trigger against busy side
      if (!is_async && rx_busy_i) begin
        nxt_st.tx_go_p = 1'b0;
      end
      if (!is_async && tx_busy_i) begin
        nxt_st.rx_go_p = 1'b0;
      end
      if (wb[SPI_CTL_RX_GO]) begin
        nxt_st.buf_full = 1'b0;
      end
      if (wb[SPI_CTL_OVR]) begin
        nxt_st.ovr = 1'b0;
      end
      if (wb[SPI_CTL_PAR]) begin
        nxt_st.par = 1'b0;
      end
      if (wb[SPI_CTL_FRM]) begin
        nxt_st.frm = 1'b0;
      end
    end
    if (wr && hit(adr_i, SPI_ADR_FLAGS)) begin
      nxt_st.flg = st_ff.flg & ~wb[2:0];
    end
    // Hardware events, set wins over clear; ungated by enables
    set_ev = 3'h0;
    set_ev[SPI_BIT_TX] = tx_shift_done_i;
    // receive done, overrun suppressed, fault delayed
    set_ev[SPI_BIT_RX] = (rx_ev & ~any_pf & ~ovr_bad) | gap_done;
    set_ev[SPI_BIT_ERR] = rx_ev & (any_pf | ovr_bad);
    nxt_st.flg = nxt_st.flg | set_ev;
    if (rx_ev) begin
      nxt_st.buf_full = 1'b1;
      nxt_st.ovr = nxt_st.ovr | ovr_bad;
      nxt_st.par = nxt_st.par | par_bad;
      nxt_st.frm = nxt_st.frm | frm_bad;
    end
    if (!nxt_st.rx_on) begin
      nxt_st.ovr = 1'b0;
      nxt_st.par = 1'b0;
      nxt_st.frm = 1'b0;
      nxt_st.buf_full = 1'b0;
    end
    // Read data mux; unmapped reads return zero
    nxt_st.rdat = 32'h00000000;
    if (rd) begin
      if (hit(adr_i, SPI_ADR_ENABLE)) begin
        nxt_st.rdat[2:0] = st_ff.en;
      end else if (hit(adr_i, SPI_ADR_FLAGS)) begin
        nxt_st.rdat[2:0] = st_ff.flg;
      end else if (hit(adr_i, SPI_ADR_PRIO)) begin
        nxt_st.rdat[SPI_PRIO_LSB +: 2] = st_ff.prio;
      end else if (hit(adr_i, SPI_ADR_MODE)) begin
        nxt_st.rdat[7:0] = st_ff.mode;
      end else if (hit(adr_i, SPI_ADR_CTRL)) begin
        nxt_st.rdat[SPI_CTL_TX_ON] = st_ff.tx_on;
        nxt_st.rdat[SPI_CTL_TX_GO] = tx_busy_i;
        nxt_st.rdat[SPI_CTL_RX_ON] = st_ff.rx_on;
        nxt_st.rdat[SPI_CTL_RX_GO] = rx_busy_i;
        nxt_st.rdat[SPI_CTL_OVR] = st_ff.ovr;
        nxt_st.rdat[SPI_CTL_PAR] = st_ff.par;
        nxt_st.rdat[SPI_CTL_FRM] = st_ff.frm;
      end
    end
    // request gated by enable and mask
    nxt_st.irq = (|(st_ff.flg & st_ff.en)) && (st_ff.prio > cpu_mask_i);
    nxt_st.lvl = st_ff.prio;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; all cleared at reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.en <= SPI_RST_ENABLE;
      st_ff.flg <= SPI_RST_FLAGS;
      st_ff.prio <= SPI_RST_PRIO;
      st_ff.mode <= SPI_RST_MODE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Oscillator tick divider
  spi_tick_div #(.DIV(SPI_OSC_DIV)) u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(osc_tick)
  );

  spi_gap_seq u_gap (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(gap_start),
    .ticks_i(gap_ticks),
    .tick_i(gap_tick),
    .done_o(gap_done)
  );

  // Outputs straight from flip-flops
  assign dat_o = st_ff.rdat;
  assign ack_o = st_ff.ack;
  assign irq_o = st_ff.irq;
  assign irq_level_o = st_ff.lvl;
  assign transmit_enable_o = st_ff.tx_on;
  assign receive_enable_o = st_ff.rx_on;
  assign transmit_trigger_o = st_ff.tx_go_p;
  assign receive_trigger_o = st_ff.rx_go_p;
  assign async_mode_o = st_ff.mode[SPI_MD_ASYNC];

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_prio_zero_quiet;
    @(posedge clk_i) disable iff (rst_i)
      (st_ff.prio == 2'h0) |=> !irq_o;
  endproperty
  a_prio_zero_quiet: assert property (p_prio_zero_quiet)
    else $error("irq raised at level zero");

  property p_irq_gate;
    @(posedge clk_i) disable iff (rst_i)
      ((st_ff.flg & st_ff.en) != 3'h0 && st_ff.prio > cpu_mask_i)
      |=> irq_o && irq_level_o == $past(st_ff.prio);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("irq missing when enabled above mask");

  property p_irq_masked;
    @(posedge clk_i) disable iff (rst_i)
      (st_ff.prio <= cpu_mask_i) |=> !irq_o;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("irq raised at or below mask");

  property p_tx_set;
    @(posedge clk_i) disable iff (rst_i)
      tx_shift_done_i |=> st_ff.flg[SPI_BIT_TX];
  endproperty
  a_tx_set: assert property (p_tx_set)
    else $error("tx done flag not set");

  property p_flag_sticky;
    @(posedge clk_i) disable iff (rst_i)
      (st_ff.flg[SPI_BIT_TX] && !(wr && hit(adr_i, SPI_ADR_FLAGS)))
      |=> st_ff.flg[SPI_BIT_TX];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("flag dropped without write");

  property p_w1c;
    @(posedge clk_i) disable iff (rst_i)
      (wr && hit(adr_i, SPI_ADR_FLAGS) && wb[SPI_BIT_TX] &&
       !tx_shift_done_i) |=> !st_ff.flg[SPI_BIT_TX];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write one did not clear flag");

  sequence s_fault_start;
    gap_start;
  endsequence
  sequence s_done_later;
    ##[2:400] gap_done;
  endsequence
  property p_gap_order;
    @(posedge clk_i) disable iff (rst_i)
      s_fault_start |=> st_ff.flg[SPI_BIT_ERR] && !gap_done ##0 s_done_later;
  endproperty
  a_gap_order: assert property (p_gap_order)
    else $error("fault flag not ahead of done");

  property p_ovr_no_done;
    @(posedge clk_i) disable iff (rst_i)
      (rx_ev && ovr_bad && !gap_done && !st_ff.flg[SPI_BIT_RX])
      |=> !st_ff.flg[SPI_BIT_RX] && st_ff.flg[SPI_BIT_ERR];
  endproperty
  a_ovr_no_done: assert property (p_ovr_no_done)
    else $error("done flag set on overrun");

  property p_rxoff_clear;
    @(posedge clk_i) disable iff (rst_i)
      !st_ff.rx_on |-> !st_ff.ovr && !st_ff.par && !st_ff.frm;
  endproperty
  a_rxoff_clear: assert property (p_rxoff_clear)
    else $error("error status kept while rx off");

  // receive trigger refused while transmit busy
  property p_half_duplex;
    @(posedge clk_i) disable iff (rst_i)
      (wr && hit(adr_i, SPI_ADR_CTRL) && wb[SPI_CTL_RX_GO] && !is_async &&
       tx_busy_i) |=> !receive_trigger_o;
  endproperty
  a_half_duplex: assert property (p_half_duplex)
    else $error("rx trigger passed while tx busy");
endmodule : spi_irq

// file: verification/spi_cpu_model.sv
// CPU interrupt acceptance model facing the serial interrupt logic.
// Assumes the bench pulses ret_i once it has cleared the flag.
`timescale 1ns/10ps
module spi_cpu_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Request from the device
  input wire logic irq_i,
  input wire logic [1:0] irq_level_i,
  // Software side
  input wire logic [1:0] base_mask_i,
  input wire logic ret_i,
  // Mask level and acceptance count
  output logic [1:0] cpu_mask_o,
  output logic [7:0] accepts_o
);
  logic busy_ff; // Handler running

  // Accept a request above the mask, hold the mask until return
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_ff <= 1'b0;
      cpu_mask_o <= 2'h0;
      accepts_o <= 8'h00;
    end else if (!busy_ff && irq_i && irq_level_i > cpu_mask_o) begin
      busy_ff <= 1'b1;
      cpu_mask_o <= irq_level_i;
      accepts_o <= accepts_o + 8'h01;
    end else if (!busy_ff || ret_i) begin
      busy_ff <= 1'b0;
      cpu_mask_o <= base_mask_i;
    end
  end
endmodule : spi_cpu_model

// file: verification/spi_irq_tb.sv
// Self-checking bench for the serial interrupt logic.
// Assumes the Wishbone slave answers and the CPU model sets the mask.
`timescale 1ns/10ps
module spi_irq_tb
  import spi_pkg::*;
;
  logic clk_i, rst_i, cyc, stb, we, ack, irq, ret, ren;
  logic tx_done, rx_load, rx_stop, tmr;
  logic [17:0] adr;
  logic [31:0] wdat, rdat, q, seed;
  logic [7:0] rx_char, acc, n, c;
  logic [1:0] lvl, mask, base;
  logic odd;
  logic txb, rxb, ten, ttr, rtr, am;
  logic [3:0] sel;
  logic [7:0] tp, rp; // Trigger pulses seen
  int fail_count, num_checks, cyc_cnt, i;

  ////////////////////////////////////////////////////////////////////
  // Design and CPU model
  spi_irq dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
    .ack_o(ack), .tx_shift_done_i(tx_done), .rx_buf_load_i(rx_load),
    .rx_char_i(rx_char), .rx_stop_bit_i(rx_stop), .tx_busy_i(txb),
    .rx_busy_i(rxb), .timer_uflow_i(tmr), .cpu_mask_i(mask),
    .irq_o(irq), .irq_level_o(lvl), .transmit_enable_o(ten),
    .receive_enable_o(ren), .transmit_trigger_o(ttr),
    .receive_trigger_o(rtr), .async_mode_o(am));
  spi_cpu_model cpu_u (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq),
    .irq_level_i(lvl), .base_mask_i(base), .ret_i(ret),
    .cpu_mask_o(mask), .accepts_o(acc));

  ////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction : lfsr

  // Expected {framing, parity, overrun} status
  function automatic logic [2:0] err_exp(input logic [7:0] ch,
    input logic od, input logic stp);
    err_exp = {~stp, (^ch) != od, 1'b0};
  endfunction : err_exp

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
    input string m);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t %s got %0h exp %0h", $time, m, g, e);
    end
  endtask : chk

  // One classic Wishbone cycle, waits for ack
  task automatic wb(input logic w, input logic [17:0] a,
    input logic [7:0] d, output logic [31:0] r);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 40);
    if (ack !== 1'b1) begin
      fail_count++;
      $display("MISMATCH %0t no ack", $time);
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  // One-cycle pulse on {timer, rx load, tx done}
  task automatic ev(input logic [2:0] m);
    @(posedge clk_i);
    {tmr, rx_load, tx_done} <= m;
    @(posedge clk_i);
    {tmr, rx_load, tx_done} <= 3'h0;
  endtask : ev

  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask : tick

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////
  // Clock and timeout
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      fail_count++;
      $display("MISMATCH %0t timeout", $time);
      wrap_up();
    end
  end

  // Count trigger pulses as the shift engines would see them
  always @(posedge clk_i) begin
    if (rst_i) begin
      tp <= 8'h00;
      rp <= 8'h00;
    end else begin
      if (ttr === 1'b1) tp <= tp + 8'h01;
      if (rtr === 1'b1) rp <= rp + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {cyc, stb, we, tx_done, rx_load, tmr, ret} = 7'h00;
    {txb, rxb} = 2'b00;
    sel = 4'hF;
    adr = 18'h00000;
    wdat = 32'h00000000;
    rx_char = 8'h00;
    rx_stop = 1'b1;
    base = 2'h0;
    fail_count = 0;
    num_checks = 0;
    cyc_cnt = 0;
    seed = 32'h46CE1F32;
    rst_i = 1'b1;
    tick(6);
    rst_i <= 1'b0;
    // Reset values and an unmapped place
    wb(1'b0, SPI_ADR_ENABLE, 8'h00, q);
    chk(q[2:0], 3'h0, "enable reset");
    wb(1'b0, SPI_ADR_FLAGS, 8'h00, q);
    chk(q[2:0], 3'h0, "flags reset");
    wb(1'b0, SPI_ADR_PRIO, 8'h00, q);
    chk(q[5:4], 2'h0, "prio reset");
    wb(1'b0, 18'h00010, 8'h00, q);
    chk(q, 32'h00000000, "unmapped read");
    repeat (4) begin
      seed = lfsr(seed);
      wb(1'b1, SPI_ADR_ENABLE, {5'h00, seed[2:0]}, q);
      wb(1'b0, SPI_ADR_ENABLE, 8'h00, q);
      chk(q[2:0], seed[2:0], "enable rw");
    end
    $display("test registers done");
    // Flags set with enables off, then cleared by ones
    wb(1'b1, SPI_ADR_ENABLE, 8'h00, q);
    // Byte lane zero off: write ignored
    sel <= 4'hE;
    wb(1'b1, SPI_ADR_ENABLE, 8'h07, q);
    sel <= 4'hF;
    wb(1'b0, SPI_ADR_ENABLE, 8'h00, q);
    chk(q[2:0], 3'h0, "byte lane off");
    wb(1'b1, SPI_ADR_PRIO, 8'h30, q);
    wb(1'b1, SPI_ADR_CTRL, 8'h04, q);
    n = acc;
    ev(3'b011);
    tick(4);
    wb(1'b0, SPI_ADR_FLAGS, 8'h00, q);
    chk(q[2:0], 3'b011, "flags set");
    chk(acc, n, "request while disabled");
    wb(1'b1, SPI_ADR_FLAGS, 8'h00, q);
    wb(1'b0, SPI_ADR_FLAGS, 8'h00, q);
    chk(q[2:0], 3'b011, "zero write");
    wb(1'b1, SPI_ADR_FLAGS, 8'h01, q);
    wb(1'b0, SPI_ADR_FLAGS, 8'h00, q);
    chk(q[2:0], 3'b010, "one clears");
    wb(1'b1, SPI_ADR_FLAGS, 8'h02, q);
    $display("test flags done");
    // Every priority against every mask level
    wb(1'b1, SPI_ADR_ENABLE, 8'h01, q);
    for (i = 0; i < 16; i++) begin
      base <= i[3:2];
      wb(1'b1, SPI_ADR_PRIO, 8'(i[1:0]) << SPI_PRIO_LSB, q);
      tick(2);
      n = acc;
      ev(3'b001);
      tick(6);
      chk(acc - n, {7'h00, i[1:0] > i[3:2]}, "accept");
      chk(lvl, i[1:0], "level");
      wb(1'b1, SPI_ADR_FLAGS, 8'h01, q);
      tick(3);
      ret <= 1'b1;
      tick(1);
      ret <= 1'b0;
    end
    $display("test priority done");
    // Parity and framing faults for every clock source
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      c = seed[7:0];
      odd = seed[8];
      if ((((^c) != odd) ? 1 : 0) != ((i < 4) ? 1 : 0))
        c[7] = ~c[7];
      wb(1'b1, SPI_ADR_CTRL, 8'h00, q);
      // mode written with both directions off
      wb(1'b1, SPI_ADR_MODE, 8'h41 | 8'(odd) << SPI_MD_PODD
        | 8'(i % 4) << SPI_MD_CLK_LSB, q);
      wb(1'b1, SPI_ADR_CTRL, 8'h0C, q);
      wb(1'b1, SPI_ADR_FLAGS, 8'h07, q);
      rx_char <= c;
      rx_stop <= (i >= 4) ? 1'b0 : 1'b1;
      ev(3'b010);
      wb(1'b0, SPI_ADR_FLAGS, 8'h00, q);
      chk(q[2:0], 3'b100, "fault first");
      ev(3'b100);
      tick(25);
      wb(1'b0, SPI_ADR_FLAGS, 8'h00, q);
      chk(q[2:0], 3'b110, "done later");
      wb(1'b0, SPI_ADR_CTRL, 8'h00, q);
      chk(q[6:4], err_exp(c, odd, i < 4), "status");
    end
    $display("test fault order done");
    // Overrun without a receive trigger in between
    wb(1'b1, SPI_ADR_CTRL, 8'h00, q);
    wb(1'b1, SPI_ADR_MODE, 8'h01, q);
    chk(am, 1'b1, "async mode");
    wb(1'b1, SPI_ADR_CTRL, 8'h0C, q);
    wb(1'b1, SPI_ADR_FLAGS, 8'h07, q);
    rx_stop <= 1'b1;
    rx_char <= seed[15:8];
    ev(3'b010);
    tick(2);
    wb(1'b0, SPI_ADR_FLAGS, 8'h00, q);
    chk(q[2:0], 3'b010, "receive done");
    chk(ren, 1'b1, "receive enable");
    wb(1'b1, SPI_ADR_FLAGS, 8'h02, q);
    ev(3'b010);
    tick(25);
    wb(1'b0, SPI_ADR_FLAGS, 8'h00, q);
    chk(q[2:0], 3'b100, "overrun flags");
    wb(1'b0, SPI_ADR_CTRL, 8'h00, q);
    chk(q[6:4], 3'b001, "overrun status");
    wb(1'b1, SPI_ADR_CTRL, 8'h00, q);
    wb(1'b0, SPI_ADR_CTRL, 8'h00, q);
    chk(q[6:4], 3'b000, "status off");
    $display("test overrun done");
    // Trigger pulses and half duplex in synchronous mode
    wb(1'b1, SPI_ADR_MODE, 8'h00, q);
    chk(am, 1'b0, "sync mode");
    n = tp;
    c = rp;
    txb <= 1'b1;
    wb(1'b1, SPI_ADR_CTRL, 8'h0D, q);
    wb(1'b0, SPI_ADR_CTRL, 8'h00, q);
    chk(q[3:0], 4'h7, "control status");
    chk(ten, 1'b1, "transmit enable");
    txb <= 1'b0;
    rxb <= 1'b1;
    wb(1'b1, SPI_ADR_CTRL, 8'h07, q);
    tick(2);
    chk(tp, n, "tx trigger refused");
    chk(rp, c, "rx trigger refused");
    rxb <= 1'b0;
    wb(1'b1, SPI_ADR_CTRL, 8'h07, q);
    tick(2);
    chk(tp - n, 8'h01, "tx trigger pulse");
    wb(1'b1, SPI_ADR_CTRL, 8'h0D, q);
    tick(2);
    chk(rp - c, 8'h01, "rx trigger pulse");
    wb(1'b1, SPI_ADR_CTRL, 8'h00, q);
    $display("test triggers done");
    wrap_up();
  end
endmodule : spi_irq_tb
